/* File: bench/smts_src_model.sv */
// Purpose: Reference and trigger pulse sources for the block
// Assumes: Pulses launched just after a rising clock edge
// Notes:   Lines rest low between pulses; also watches the output
`timescale 1ns/100ps
module smts_src_model (
   input  wire logic clock_in,    // Shared decimator clock
   input  wire logic watch_in,    // Passed reference from the block
   output logic      sysref_out,  // Reference pulse line
   output logic      trig_out     // Dedicated trigger line
);
   // Both lines idle low
   initial begin
      sysref_out = 1'b0;
      trig_out   = 1'b0;
   end
   // Reference pulse, reports whether any part got through
   task automatic ref_pulse(input int hi, input int lo,
                            output logic seen);
      seen = 1'b0;
      @(posedge clock_in);
      sysref_out <= 1'b1;
      repeat (hi) begin
         #1 seen = seen | (watch_in === 1'b1);
         @(posedge clock_in);
      end
      sysref_out <= 1'b0;
      repeat (lo) @(posedge clock_in);
   endtask
   // One-cycle trigger pulse
   task automatic trig_pulse();
      @(posedge clock_in);
      trig_out <= 1'b1;
      @(posedge clock_in);
      trig_out <= 1'b0;
   endtask
endmodule // smts_src_model

/* File: bench/sysref_mask_trigger_sync_test.sv */
// Purpose: Self-checking bench for the mask and trigger block
// Assumes: Short oscillator period parameter
// Notes:   Trigger latencies are compared against the undelayed mode
`timescale 1ns/100ps
module sysref_mask_trigger_sync_test;
   import smts_pkg::*;
   localparam int HP = 4;            // Short oscillator period
   logic       clock_in;             // Decimator clock
   logic       reset_n_in;           // Synchronous reset
   logic [11:0] reg_addr_in;         // Register address
   logic       reg_wr_in;            // Write strobe
   logic [7:0] reg_wdata_in;         // Write data
   logic [7:0] reg_rdata_out;        // Read data
   logic       sysref_in, trig_in;   // From the source model
   logic       sysref_out, group_trig_out, osc_reset_out, mask_busy_out;
   int         mismatches, n_compared;
   logic       seen, seen_d, o;      // Pulse seen, osc at output
   logic [7:0] d, dval;              // Read value, delay setting
   int         n, b, m, c;           // Latencies, counts
   logic [11:0] rst_addr [5] = '{SMTS_ADDR_MASK_CTRL, SMTS_ADDR_TRIG_SET,
      SMTS_ADDR_TRIG_COMP, SMTS_ADDR_SYNC_MODE, 12'h123}; // Map and a hole

   smts_top #(.H_PERIOD(HP)) u_smts_top (.clock_in(clock_in),
      .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .sysref_in(sysref_in),
      .trig_in(trig_in), .sysref_out(sysref_out),
      .group_trig_out(group_trig_out), .osc_reset_out(osc_reset_out),
      .mask_busy_out(mask_busy_out));
   smts_src_model u_smts_src_model (.clock_in(clock_in),
      .watch_in(sysref_out), .sysref_out(sysref_in),
      .trig_out(trig_in));

   // Clock at 40 ns
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   // Verdict and end of run
   task automatic end_sim();
      if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask
   // Wait edges, then let them settle
   task automatic step(input int k);
      repeat (k) @(posedge clock_in);
      #1;
   endtask
   // One register write
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clock_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
      @(posedge clock_in);
      reg_wr_in    <= 1'b0;
   endtask
   // One register read, data one edge after the address
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clock_in);
      reg_addr_in <= a;
      step(1);
      v = reg_rdata_out;
   endtask
   // Launch a trigger source, count cycles to the group trigger
   task automatic fire(input logic use_ref);
      step(8);
      n = 0;
      fork
         if (use_ref) u_smts_src_model.ref_pulse(2, 2, seen_d);
         else u_smts_src_model.trig_pulse();
      join_none
      do begin
         step(1);
         n++;
      end while (group_trig_out !== 1'b1 && n < 300);
      o = osc_reset_out;
   endtask
   // Hang guard
   initial begin
      #(40 * 20000);
      mismatches++;
      end_sim();
   end
   // Main sequence
   initial begin
      mismatches = 0;
      n_compared = 0;
      reg_addr_in = 12'h000;
      reg_wr_in = 1'b0;
      reg_wdata_in = 8'h00;
      reset_n_in = 1'b0;
      void'($urandom(32'h16EC));
      repeat (2) @(posedge clock_in);
      reset_n_in <= 1'b1;
      // Reset values of the map, one unmapped place
      foreach (rst_addr[i]) begin
         rd(rst_addr[i], d);
         chk(d, SMTS_RST_BYTE);
      end
      // Delay setting copied, computed value read-only
      dval = 8'($urandom_range(1, 6));
      wr(SMTS_ADDR_TRIG_SET, dval);
      wr(SMTS_ADDR_TRIG_COMP, ~dval);
      wr(12'h123, 8'hFF);
      rd(SMTS_ADDR_TRIG_COMP, d);
      chk(d, dval);
      rd(12'h123, d);
      chk(d, 8'h00);
      // Masking with smallest, largest and a random count
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(1, 14);
         wr(SMTS_ADDR_MASK_CTRL, {3'h3, c[3:0], 1'b0});
         step(3);
         chk(mask_busy_out, 8'h01);
         u_smts_src_model.ref_pulse(2, 2, seen);
         chk(seen, 8'h01);
         for (int k = 0; k <= c; k++) begin
            u_smts_src_model.ref_pulse(2, 2, seen);
            chk(seen, 8'h00);
         end
         step(2);
         chk(mask_busy_out, 8'h00);
         u_smts_src_model.ref_pulse(2, 2, seen);
         chk(seen, 8'h01);
      end
      // Start without enable does nothing
      wr(SMTS_ADDR_MASK_CTRL, 8'h40);
      rd(SMTS_ADDR_MASK_CTRL, d);
      chk(d, 8'h00);
      u_smts_src_model.ref_pulse(2, 2, seen);
      chk(seen, 8'h01);
      // Disable bit blocks the reference
      wr(SMTS_ADDR_MASK_CTRL, 8'h01);
      u_smts_src_model.ref_pulse(2, 2, seen);
      chk(seen, 8'h00);
      wr(SMTS_ADDR_MASK_CTRL, 8'h00);
      // Undelayed modes give the base latency, delayed modes add the setting
      wr(SMTS_ADDR_SYNC_MODE, {6'h00, SMTS_MODE_DIRECT});
      fire(1'b0);
      b = n;
      wr(SMTS_ADDR_SYNC_MODE, {6'h00, SMTS_MODE_SYSREF});
      fire(1'b1);
      chk(n[7:0], b[7:0]);
      wr(SMTS_ADDR_SYNC_MODE, {6'h00, SMTS_MODE_TRIG_DED});
      fire(1'b0);
      chk(n[7:0], b[7:0] + dval);
      chk(o, 8'h00);
      wr(SMTS_ADDR_SYNC_MODE, {6'h00, SMTS_MODE_TRIG_REF});
      fire(1'b1);
      chk(n[7:0], b[7:0] + dval);
      // Oscillator reset with trigger, then each period
      wr(SMTS_ADDR_SYNC_MODE, 8'h11);
      fire(1'b0);
      chk(o, 8'h01);
      m = 0;
      do begin
         step(1);
         m++;
      end while (osc_reset_out !== 1'b1 && m < 50);
      chk(m[7:0], 8'(HP));
      wr(SMTS_ADDR_SYNC_MODE, 8'h01);
      m = 0;
      repeat (3 * HP) begin
         step(1);
         m += int'(osc_reset_out === 1'b1);
      end
      chk(m[7:0], 8'h00);
      // Auto step raises the delay after each output
      wr(SMTS_ADDR_SYNC_MODE, 8'h05);
      fire(1'b0);
      rd(SMTS_ADDR_TRIG_COMP, d);
      chk(d, dval + 8'h01);
      fire(1'b0);
      chk(n[7:0], b[7:0] + dval + 8'h01);
      // Writing the setting overrides the stepped value
      wr(SMTS_ADDR_TRIG_SET, 8'h02);
      fire(1'b0);
      chk(n[7:0], b[7:0] + 8'h02);
      // Reserved bits of the mode register read zero
      wr(SMTS_ADDR_SYNC_MODE, 8'hFF);
      rd(SMTS_ADDR_SYNC_MODE, d);
      chk(d, 8'h17);
      end_sim();
   end
endmodule // sysref_mask_trigger_sync_test

/* File: common/smts_ctl_if.sv */
// Purpose: Control and status between top and its two stages
// Assumes: One clock domain
// Notes:   Plain signals only, no clocking
`timescale 1ns/100ps
interface smts_ctl_if;
   logic       mask_enable;  // Masker enable and freeze
   logic       mask_start;   // Start level from control bit
   logic [3:0] mask_count;   // Edges to drop minus one
   logic       mask_done;    // One-cycle end of masking
   logic       mask_gate;    // Blocks the reference output
   logic [7:0] trig_setting; // Programmed delay
   logic       trig_load;    // Setting written this cycle
   logic       auto_step;    // Step delay after each output
   logic       osc_en;       // Periodic oscillator resets
   logic       direct;       // Pass trigger without delay
   logic       trig_pulse;   // Selected trigger edge
   logic       trig_fire;    // Delayed trigger, registered
   logic       osc_reset;    // Oscillator reset, registered
   logic [7:0] delay_now;    // Delay in use, registered
   modport top  (output mask_enable, mask_start, mask_count,
                 trig_setting, trig_load, auto_step, osc_en,
                 direct, trig_pulse,
                 input mask_done, mask_gate, trig_fire,
                 osc_reset, delay_now);
   modport mask (input mask_enable, mask_start, mask_count,
                 output mask_done, mask_gate);
   modport trig (input trig_setting, trig_load, auto_step,
                 osc_en, direct, trig_pulse,
                 output trig_fire, osc_reset, delay_now);
endinterface

/* File: common/smts_pkg.sv */
// Purpose: Shared constants for the reference mask and trigger stage
// Assumes: Register port with 12-bit address and 8-bit data
// Notes:   Offsets, field positions, reset values and mode codes
package smts_pkg;
   // Register port widths
   localparam int SMTS_ADDR_W = 12;
   localparam int SMTS_DATA_W = 8;
   // Register offsets
   localparam logic [11:0] SMTS_ADDR_MASK_CTRL = 12'hD4D;
   localparam logic [11:0] SMTS_ADDR_TRIG_SET  = 12'hE20;
   localparam logic [11:0] SMTS_ADDR_TRIG_COMP = 12'hE21;
   localparam logic [11:0] SMTS_ADDR_SYNC_MODE = 12'hE24;
   // Edge mask control fields
   localparam int SMTS_BIT_START   = 6;
   localparam int SMTS_BIT_ENABLE  = 5;
   localparam int SMTS_CNT_LSB     = 1;
   localparam int SMTS_CNT_W       = 4;
   localparam int SMTS_BIT_DISABLE = 0;
   localparam logic [7:0] SMTS_MASK_CTRL_WMASK = 8'h7F;
   // Sync mode control fields
   localparam int SMTS_BIT_OSC_EN  = 4;
   localparam int SMTS_BIT_AUTO    = 2;
   localparam int SMTS_MODE_LSB    = 0;
   // Reset values
   localparam logic [7:0] SMTS_RST_BYTE = 8'h00;
   // Oscillator reset period in decimator clock cycles
   localparam int SMTS_OSC_PERIOD_DEF = 16;
   // Group sync modes
   typedef enum logic [1:0] {
      SMTS_MODE_SYSREF    = 2'h0,
      SMTS_MODE_TRIG_DED  = 2'h1,
      SMTS_MODE_TRIG_REF  = 2'h2,
      SMTS_MODE_DIRECT    = 2'h3
   } smts_mode_t;
   // Edge mask states, Gray from idle to drain
   typedef enum logic [2:0] {
      SMTS_MS_IDLE  = 3'h0,
      SMTS_MS_ARMED = 3'h1,
      SMTS_MS_PASS  = 3'h3,
      SMTS_MS_MASK  = 3'h2,
      SMTS_MS_DRAIN = 3'h6
   } smts_mask_state_t;
endpackage

/* File: logic/smts_edge_mask.sv */
// Purpose: Passes first reference edge, then drops a set count
// Assumes: Reference input synchronous to clock_in
// Notes:   Enable low freezes every flop of this stage
`timescale 1ns/100ps
module smts_edge_mask (
   input  wire logic    clock_in,
   input  wire logic    reset_n_in,
   input  wire logic    sysref_in,
   smts_ctl_if.mask     ctl
);
   import smts_pkg::*;
   // Whole stage state
   typedef struct packed {
      smts_mask_state_t  state;
      logic [3:0]        left;
      logic              prev;
   } smts_mask_st_t;
   smts_mask_st_t st_reg;
   smts_mask_st_t st_next;
   logic          rise;
   // Next state
   always_comb begin
      st_next       = st_reg;
      rise          = sysref_in & ~st_reg.prev;
      ctl.mask_done = 1'b0;
      if (ctl.mask_enable) begin
         st_next.prev = sysref_in;
         case (st_reg.state)
            SMTS_MS_IDLE: begin
               if (ctl.mask_start) begin
                  st_next.state = SMTS_MS_ARMED;
               end
            end
            SMTS_MS_ARMED: begin
               // First edge goes through untouched
               if (rise) begin
                  st_next.state = SMTS_MS_PASS;
                  st_next.left  = ctl.mask_count;
               end
            end
            SMTS_MS_PASS: begin
               // Let the passed pulse finish whole
               if (!sysref_in) begin
                  st_next.state = SMTS_MS_MASK;
               end
            end
            SMTS_MS_MASK: begin
               // Count dropped edges, count of zero drops one
               if (rise) begin
                  if (st_reg.left == 4'h0) begin
                     st_next.state = SMTS_MS_DRAIN;
                  end else begin
                     st_next.left = st_reg.left - 4'h1;
                  end
               end
            end
            default: begin
               // Hold the last dropped pulse until it falls
               if (!sysref_in) begin
                  st_next.state = SMTS_MS_IDLE;
                  ctl.mask_done = 1'b1;
               end
            end
         endcase
      end
   end
   // Gate while dropping edges
   assign ctl.mask_gate = (st_reg.state == SMTS_MS_MASK) ||
                          (st_reg.state == SMTS_MS_DRAIN);
   // State register
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         st_reg <= '{SMTS_MS_IDLE, 4'h0, 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end
   sequence s_first_edge;
      ctl.mask_enable && st_reg.state == SMTS_MS_ARMED && rise;
   endsequence
   sequence s_passing;
      !ctl.mask_gate ##1 st_reg.state == SMTS_MS_PASS;
   endsequence
   a_first_edge_pass : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      s_first_edge |-> s_passing)
      else $error("first reference edge was not passed");
   a_count_load : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      s_first_edge |=> st_reg.left == $past(ctl.mask_count))
      else $error("drop count not loaded on first edge");
   a_frozen_off : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      !ctl.mask_enable |=> $stable(st_reg))
      else $error("masker changed while disabled");
endmodule // smts_edge_mask

/* File: logic/smts_top.sv */
// Purpose: Reference edge masking and group trigger delay
// Assumes: Register port is the serial port's internal side
// Notes:   Reference disable acts on the output without a flop
`timescale 1ns/100ps
module smts_top #(
   parameter int H_PERIOD = smts_pkg::SMTS_OSC_PERIOD_DEF
) (
   input  wire logic                           clock_in,
   input  wire logic                           reset_n_in,
   input  wire logic [smts_pkg::SMTS_ADDR_W-1:0] reg_addr_in,
   input  wire logic                           reg_wr_in,
   input  wire logic [smts_pkg::SMTS_DATA_W-1:0] reg_wdata_in,
   output wire logic [smts_pkg::SMTS_DATA_W-1:0] reg_rdata_out,
   input  wire logic                           sysref_in,
   input  wire logic                           trig_in,
   output wire logic                           sysref_out,
   output wire logic                           group_trig_out,
   output wire logic                           osc_reset_out,
   output wire logic                           mask_busy_out
);
   import smts_pkg::*;

   // Software visible state and edge history
   typedef struct packed {
      logic [7:0] mask_ctrl;  // Edge mask control
      logic [7:0] trig_set;   // Programmed trigger delay
      logic       osc_en;     // Periodic oscillator reset
      logic       auto_step;  // Delay auto step
      smts_mode_t mode;       // Group sync mode
      logic       sref_prev;  // Last masked reference level
      logic       trig_prev;  // Last trigger input level
      logic [7:0] rdata;      // Read data register
   } smts_top_st_t;

   smts_top_st_t st_reg;     // Registered state
   smts_top_st_t st_next;    // Next state
   smts_ctl_if   ctl ();     // Links to both stages

   logic       wr_mask;      // Write to edge mask control
   logic       wr_set;       // Write to delay setting
   logic       wr_comp;      // Write to computed delay
   logic       wr_mode;      // Write to sync mode control
   logic       sref_rise;    // Rising edge of passed reference
   logic       trig_rise;    // Rising edge of trigger input
   logic       from_ref;     // Mode takes trigger from reference
   logic [7:0] rd_value;     // Value at the read address

   // Address decode for writes
   // Exact match only, so no register has an alias; the
   // computed delay gets a strobe of its own only so that
   // its checker can see writes that must be ignored
   always_comb begin
      wr_mask = 1'b0;
      wr_set  = 1'b0;
      wr_comp = 1'b0;
      wr_mode = 1'b0;
      if (!reg_wr_in) begin
         // No write this cycle
         wr_mask = 1'b0;
      end else if (reg_addr_in == SMTS_ADDR_MASK_CTRL) begin
         wr_mask = 1'b1;
      end else if (reg_addr_in == SMTS_ADDR_TRIG_SET) begin
         wr_set = 1'b1;
      end else if (reg_addr_in == SMTS_ADDR_TRIG_COMP) begin
         // Read-only, write has no effect
         wr_comp = 1'b1;
      end else if (reg_addr_in == SMTS_ADDR_SYNC_MODE) begin
         wr_mode = 1'b1;
      end
   end

   // Read mux, unmapped and reserved bits read zero
   // Decoded from the live address and registered below,
   // so read data trail the address by one cycle
   always_comb begin
      rd_value = 8'h00;
      if (reg_addr_in == SMTS_ADDR_MASK_CTRL) begin
         rd_value = st_reg.mask_ctrl & SMTS_MASK_CTRL_WMASK;
      end else if (reg_addr_in == SMTS_ADDR_TRIG_SET) begin
         rd_value = st_reg.trig_set;
      end else if (reg_addr_in == SMTS_ADDR_TRIG_COMP) begin
         rd_value = ctl.delay_now;
      end else if (reg_addr_in == SMTS_ADDR_SYNC_MODE) begin
         rd_value[SMTS_BIT_OSC_EN]  = st_reg.osc_en;
         rd_value[SMTS_BIT_AUTO]    = st_reg.auto_step;
         rd_value[SMTS_MODE_LSB+:2] = st_reg.mode;
      end
   end

   // Edge detection and trigger source selection
   // The trigger sees the reference after masking and
   // disable, so a dropped edge never starts a delay
   always_comb begin
      sref_rise = sysref_out & ~st_reg.sref_prev;
      trig_rise = trig_in & ~st_reg.trig_prev;
      from_ref  = (st_reg.mode == SMTS_MODE_SYSREF) ||
                  (st_reg.mode == SMTS_MODE_TRIG_REF);
   end

   // Register file next state
   // Edge history and read data are taken every cycle;
   // the write strobes gate the software fields, and the end of masking also clears the start bit
   always_comb begin
      st_next           = st_reg;
      st_next.sref_prev = sysref_out;
      st_next.trig_prev = trig_in;
      st_next.rdata     = rd_value;
      if (wr_mask) begin
         st_next.mask_ctrl = reg_wdata_in & SMTS_MASK_CTRL_WMASK;
         // Start only taken together with enable
         if (!reg_wdata_in[SMTS_BIT_ENABLE]) begin
            st_next.mask_ctrl[SMTS_BIT_START] = 1'b0;
         end
      end else if (ctl.mask_done) begin
         // Self clear, a same-cycle write wins
         st_next.mask_ctrl[SMTS_BIT_START] = 1'b0;
      end
      if (wr_set) begin
         st_next.trig_set = reg_wdata_in;
      end
      if (wr_mode) begin
         st_next.osc_en    = reg_wdata_in[SMTS_BIT_OSC_EN];
         st_next.auto_step = reg_wdata_in[SMTS_BIT_AUTO];
         st_next.mode      =
            smts_mode_t'(reg_wdata_in[SMTS_MODE_LSB+:2]);
      end
   end

   // State register
   // Synchronous reset returns every field to zero
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         st_reg <= '{SMTS_RST_BYTE, SMTS_RST_BYTE, 1'b0, 1'b0,
                     SMTS_MODE_SYSREF, 1'b0, 1'b0, SMTS_RST_BYTE};
      end else begin
         st_reg <= st_next;
      end
   end

   // Masker control
   assign ctl.mask_enable = st_reg.mask_ctrl[SMTS_BIT_ENABLE];
   assign ctl.mask_start  = st_reg.mask_ctrl[SMTS_BIT_START];
   assign ctl.mask_count  =
      st_reg.mask_ctrl[SMTS_CNT_LSB+:SMTS_CNT_W];

   // Trigger stage control
   // The stage takes its delay from the write data in the
   // cycle of the write, so no cycle is lost on a reload
   assign ctl.trig_setting = reg_wdata_in;
   assign ctl.trig_load    = wr_set;
   assign ctl.auto_step    = st_reg.auto_step;
   assign ctl.osc_en       = st_reg.osc_en;
   assign ctl.direct       = (st_reg.mode == SMTS_MODE_SYSREF) ||
                             (st_reg.mode == SMTS_MODE_DIRECT);
   assign ctl.trig_pulse   = from_ref ? sref_rise : trig_rise;

   // Reference output, disable bit acts without a flop
   assign sysref_out = sysref_in
                       & ~st_reg.mask_ctrl[SMTS_BIT_DISABLE]
                       & ~ctl.mask_gate;

   // Outputs
   // Busy mirrors the start bit, which clears itself
   assign reg_rdata_out  = st_reg.rdata;
   assign group_trig_out = ctl.trig_fire;
   assign osc_reset_out  = ctl.osc_reset;
   assign mask_busy_out  = ctl.mask_start;

   // Edge masking stage
   // Sees the raw reference, so the disable bit does not
   // hold up its count of edges
   smts_edge_mask u_mask (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .sysref_in  (sysref_in),
      .ctl        (ctl.mask)
   );

   // Trigger delay and oscillator reset stage
   // Runs on the same decimator clock as this module
   smts_trig_delay #(
      .H_PERIOD (H_PERIOD)
   ) u_trig (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .ctl        (ctl.trig)
   );

   // Checks on the register file and the outputs
   // A write that hits no writable register
   sequence s_write_ignored;
      reg_wr_in && !wr_mask && !wr_set && !wr_mode;
   endsequence

   a_write_ignored : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      s_write_ignored |=>
      $stable(st_reg.trig_set) && $stable(st_reg.mode))
      else $error("ignored write changed a register");

   a_osc_with_trig : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (group_trig_out && $past(ctl.osc_en)) |-> osc_reset_out)
      else $error("no oscillator reset with trigger");

   a_busy_falls : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(mask_busy_out) |->
      ($past(ctl.mask_done) || $past(wr_mask)))
      else $error("start bit cleared without cause");

   a_rdata_setting : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (reg_addr_in == SMTS_ADDR_TRIG_SET && !wr_set) |=>
      reg_rdata_out == st_reg.trig_set)
      else $error("delay setting read back wrong");

   a_start_self_clear : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (ctl.mask_done && !wr_mask) |=>
      !st_reg.mask_ctrl[SMTS_BIT_START])
      else $error("start bit stayed set after masking");

   a_disable_blocks : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      st_reg.mask_ctrl[SMTS_BIT_DISABLE] |-> !sysref_out)
      else $error("reference passed while disabled");

   a_start_needs_en : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (wr_mask && !reg_wdata_in[SMTS_BIT_ENABLE]) |=>
      !st_reg.mask_ctrl[SMTS_BIT_START])
      else $error("start accepted while masker disabled");

   a_computed_ro : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (wr_comp && !ctl.auto_step) |=>
      ctl.delay_now == $past(ctl.delay_now))
      else $error("computed delay changed by a write");

   a_mode_direct : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg.mode == SMTS_MODE_DIRECT && trig_rise &&
       !wr_mode) |=> ##0 group_trig_out || $past(ctl.trig_fire))
      else $error("direct mode trigger not passed");

   a_setting_loads : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      wr_set |=> ctl.delay_now == $past(reg_wdata_in))
      else $error("delay setting not taken into use");

endmodule // smts_top

/* File: logic/smts_trig_delay.sv */
// Purpose: Delays the group trigger and paces oscillator resets
// Assumes: Runs on the decimator clock
// Notes:   Triggers arriving while one is in flight are dropped
`timescale 1ns/100ps
module smts_trig_delay #(
   parameter int H_PERIOD = smts_pkg::SMTS_OSC_PERIOD_DEF
) (
   input  wire logic    clock_in,
   input  wire logic    reset_n_in,
   smts_ctl_if.trig     ctl
);
   import smts_pkg::*;
   localparam int OW = (H_PERIOD > 1) ? $clog2(H_PERIOD) : 1;
   localparam logic [OW-1:0] H_RELOAD = OW'(H_PERIOD - 1);
   // Whole stage state
   typedef struct packed {
      logic          busy;
      logic [7:0]    cnt;
      logic [7:0]    delay_now;
      logic          fire;
      logic          osc_run;
      logic [OW-1:0] osc_cnt;
      logic          osc_pulse;
   } smts_trig_st_t;
   smts_trig_st_t st_reg;
   smts_trig_st_t st_next;
   logic          fire_now;
   // Next state
   always_comb begin
      st_next           = st_reg;
      st_next.osc_pulse = 1'b0;
      fire_now          = 1'b0;
      // Delay countdown, output D+1 cycles after input
      if (st_reg.busy) begin
         if (st_reg.cnt == 8'h00) begin
            fire_now     = 1'b1;
            st_next.busy = 1'b0;
         end else begin
            st_next.cnt = st_reg.cnt - 8'h01;
         end
      end else if (ctl.trig_pulse) begin
         if (ctl.direct || st_reg.delay_now == 8'h00) begin
            fire_now = 1'b1;
         end else begin
            st_next.busy = 1'b1;
            st_next.cnt  = st_reg.delay_now - 8'h01;
         end
      end
      st_next.fire = fire_now;
      // Oscillator resets on trigger, then every H cycles
      if (!ctl.osc_en) begin
         st_next.osc_run = 1'b0;
      end else if (fire_now) begin
         st_next.osc_pulse = 1'b1;
         st_next.osc_run   = 1'b1;
         st_next.osc_cnt   = H_RELOAD;
      end else if (st_reg.osc_run) begin
         if (st_reg.osc_cnt == '0) begin
            st_next.osc_pulse = 1'b1;
            st_next.osc_cnt   = H_RELOAD;
         end else begin
            st_next.osc_cnt = st_reg.osc_cnt - OW'(1);
         end
      end
      // Delay in use: reload on write, step after output
      if (ctl.trig_load) begin
         st_next.delay_now = ctl.trig_setting;
      end else if (fire_now && ctl.auto_step) begin
         st_next.delay_now = st_reg.delay_now + 8'h01;
      end
   end
   assign ctl.trig_fire = st_reg.fire;
   assign ctl.osc_reset = st_reg.osc_pulse;
   assign ctl.delay_now = st_reg.delay_now;
   // State register
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   a_delay_exact : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!st_reg.busy && ctl.trig_pulse && !ctl.direct &&
       st_reg.delay_now == 8'h02) |-> ##3 ctl.trig_fire)
      else $error("trigger delay count wrong");
   a_auto_step : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (fire_now && ctl.auto_step && !ctl.trig_load) |=>
      st_reg.delay_now == 8'($past(st_reg.delay_now) + 8'h01))
      else $error("delay not stepped after trigger");
   a_osc_off : assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      !ctl.osc_en |=> !ctl.osc_reset)
      else $error("oscillator reset while disabled");
endmodule // smts_trig_delay
